// ==== rwf_fill.sv ====
`timescale 1ns/1ns
module rwf_fill
  import rwf_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // media write stream
  output      logic        med_valid,
  output      logic [31:0] med_data,
  output      logic [63:0] med_lba,
  output      logic        med_last,
  input  wire logic        med_ready,
  input  wire logic        med_error,
  input  wire logic        med_realloc,
  // command status
  output      logic        fill_active,
  output      logic        cmd_cmplt
);

  function automatic logic fn_valid(input logic [15:0] f);
    fn_valid = (f == FN_BG_PAT) || (f == FN_BG_SEC) ||
               (f == FN_BLK_PAT) || (f == FN_BLK_SEC);
  endfunction

  function automatic logic fn_bg(input logic [15:0] f);
    fn_bg = (f == FN_BG_PAT) || (f == FN_BG_SEC);
  endfunction

  function automatic logic fn_sec(input logic [15:0] f);
    fn_sec = (f == FN_BG_SEC) || (f == FN_BLK_SEC);
  endfunction

  rwf_regs_t   q;
  rwf_regs_t   n;
  rwf_sbuf_if  sb();

  logic        acc;
  logic        fire;
  logic        hit;
  logic [31:0] rdv;
  logic        fin;
  logic        fin_err;
  logic        set_init;
  logic        clr_init;
  logic [63:0] last_lba;
  logic [64:0] range_end;
  logic [63:0] end_lba;
  logic        range_bad;
  logic [15:0] nf;

  rwf_sbuf u_sbuf (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (sb.mem)
  );

  always_comb
  begin
    n        = q;
    n.cmplt  = 1'b0;
    acc      = psel & penable & ~q.pready;
    fire     = psel & penable & q.pready;
    hit      = 1'b1;
    rdv      = 32'h0000_0000;
    fin      = 1'b0;
    fin_err  = 1'b0;
    set_init = 1'b0;
    clr_init = 1'b0;
    nf       = pwdata[15:0];
    sb.wr_en   = 1'b0;
    sb.wr_addr = q.wptr;
    sb.wr_data = pwdata;
    sb.rd_addr = q.widx;

    // hidden area limits the user range when enabled
    last_lba  = q.hid_en ? q.hidden : q.native; // (R4)
    range_end = {1'b0, q.start} + {1'b0, q.count} - 65'h0_0000_0000_0000_0001;
    end_lba   = (q.count == 64'h0) ? last_lba : range_end[63:0]; // (R3)
    range_bad = (q.start > last_lba) ||
                ((q.count != 64'h0) && (range_end > {1'b0, last_lba})); // (R6)

    // one wait state: answer registered in the cycle after access starts
    n.pready = acc;
    if (A_FUNC == paddr)
    begin
      rdv = {16'h0000, q.func};
    end
    else if (paddr == A_START_LO)
    begin
      rdv = q.start[31:0];
    end
    else if (paddr == A_START_HI)
    begin
      rdv = q.start[63:32];
    end
    else if (paddr == A_COUNT_LO)
    begin
      rdv = q.count[31:0];
    end
    else if (paddr == A_COUNT_HI)
    begin
      rdv = q.count[63:32];
    end
    else if (paddr == A_PATTERN)
    begin
      rdv = q.pattern;
    end
    else if (paddr == A_NATIVE_LO)
    begin
      rdv = q.native[31:0];
    end
    else if (paddr == A_NATIVE_HI)
    begin
      rdv = q.native[63:32];
    end
    else if (paddr == A_HIDDEN_LO)
    begin
      rdv = q.hidden[31:0];
    end
    else if (paddr == A_HIDDEN_HI)
    begin
      rdv = q.hidden[63:32];
    end
    else if (paddr == A_HIDDEN_EN)
    begin
      rdv = {31'h0000_0000, q.hid_en};
    end
    else if (paddr == A_EVENT || paddr == A_DATA)
    begin
      rdv = 32'h0000_0000;
    end
    else if (paddr == A_TF_A)
    begin
      rdv = {q.tf_cyl_hi, q.tf_cyl_lo, q.tf_num, q.tf_cnt};
    end
    else if (paddr == A_TF_B)
    begin
      rdv = {16'h0000, q.tf_stat, q.tf_err};
    end
    else if (paddr == A_SCT_STAT)
    begin
      rdv = {14'h0000, q.active, q.init, q.sct_err}; // (R18)
    end
    else if (paddr == A_LBA_LO)
    begin
      rdv = q.lba[31:0]; // (R18)
    end
    else if (paddr == A_LBA_HI)
    begin
      rdv = q.lba[63:32];
    end
    else if (paddr == A_REALLOC)
    begin
      rdv = q.realloc;
    end
    else
    begin
      hit = 1'b0;
    end
    if (acc)
    begin
      n.prdata  = pwrite ? 32'h0000_0000 : rdv;
      n.pslverr = ~hit;
    end
    else
    begin
      n.pslverr = 1'b0;
    end

    // reassignment runs beside the fill, only counted here
    if (med_realloc)
    begin
      n.realloc = q.realloc + 32'h0000_0001; // (R5)
    end

    // fill engine
    case (q.st)
      ST_FETCH:
      begin
        n.st = ST_LOAD;
      end
      ST_LOAD:
      begin
        n.med_valid = 1'b1;
        n.med_data  = q.sec ? sb.rd_data : q.pattern; // (R20)
        n.med_lba   = q.lba;
        n.med_last  = (q.widx == SB_LAST);
        n.st        = ST_SEND;
      end
      ST_SEND:
      begin
        if (med_ready)
        begin
          n.med_valid = 1'b0;
          n.med_last  = 1'b0;
          if (!q.med_last)
          begin
            n.widx = q.widx + 7'h01;
            n.st   = ST_FETCH;
          end
          else if (med_error)
          begin
            fin     = 1'b1;
            fin_err = 1'b1;
          end
          else if (q.lba == q.end_lba)
          begin
            fin      = 1'b1;
            set_init = q.whole; // (R8)
          end
          else
          begin
            n.lba  = q.lba + 64'h0000_0000_0000_0001; // (R2)
            n.widx = 7'h00;
            n.st   = ST_FETCH;
          end
        end
      end
      default:
      begin
        n.st = q.st;
      end
    endcase

    if (fin)
    begin
      n.st     = ST_IDLE;
      n.active = 1'b0;
      if (fin_err)
      begin
        n.sct_err = q.bg ? EXT_BG_UNREC : EXT_BLK_UNREC; // (R13) (R14) (R17)
      end
      else
      begin
        n.sct_err = EXT_OK; // (R13)
      end
      if (!q.bg)
      begin
        // blocking: completion only now
        n.cmplt = 1'b1; // (R15)
        if (fin_err)
        begin
          n.tf_err  = TF_ER_ABORT;
          n.tf_cnt  = EXT_BLK_UNREC[7:0]; // (R16)
          n.tf_num  = EXT_BLK_UNREC[15:8];
          n.tf_stat = TF_ST_ERR;
        end
        else
        begin
          n.tf_stat = TF_ST_OK;
        end
      end
    end

    // register writes take effect at the completing edge
    if (fire && pwrite)
    begin
      if (paddr == A_FUNC)
      begin
        // blocking fill in progress: host must wait, a new key is ignored
        if (!(q.active && !q.bg)) // (R21)
        begin
          n.func      = nf;
          n.cmplt     = 1'b0;
          n.med_valid = 1'b0;
          n.med_last  = 1'b0;
          n.tf_cyl_lo = 8'h00;
          n.tf_cyl_hi = 8'h00;
          if (!fn_valid(nf) || range_bad) // (R19)
          begin
            n.st      = ST_IDLE;
            n.active  = 1'b0;
            n.cmplt   = 1'b1;
            n.sct_err = fn_valid(nf) ? EXT_RANGE : EXT_BAD_FUNC; // (R6)
            n.tf_err  = TF_ER_ABORT;
            n.tf_cnt  = n.sct_err[7:0]; // (R16)
            n.tf_num  = n.sct_err[15:8];
            n.tf_stat = TF_ST_ERR;
          end
          else
          begin
            n.bg        = fn_bg(nf); // (R19)
            n.sec       = fn_sec(nf);
            n.active    = 1'b1;
            n.sct_err   = EXT_RUN; // (R13)
            n.lba       = q.start; // (R2)
            n.end_lba   = end_lba;
            n.whole     = (q.start == 64'h0) && (end_lba == last_lba);
            n.wptr      = 7'h00;
            n.widx      = 7'h00;
            clr_init    = 1'b1; // (R9)
            n.tf_err    = 8'h00; // (R1)
            n.tf_cnt    = 8'h00;
            n.tf_num    = 8'h00;
            n.tf_cyl_lo = TF_XFER_LO; // (R1)
            n.tf_cyl_hi = TF_XFER_HI;
            n.tf_stat   = TF_ST_OK;
            if (fn_sec(nf))
            begin
              // ready for the one data sector
              n.st = ST_RECV;
            end
            else
            begin
              n.st = ST_FETCH;
              if (fn_bg(nf))
              begin
                n.cmplt = 1'b1; // (R11)
              end
              else
              begin
                n.tf_stat = TF_ST_BUSY; // (R15)
              end
            end
          end
        end
      end
      else if (paddr == A_START_LO)
      begin
        n.start[31:0] = pwdata;
      end
      else if (paddr == A_START_HI)
      begin
        n.start[63:32] = pwdata;
      end
      else if (paddr == A_COUNT_LO)
      begin
        n.count[31:0] = pwdata;
      end
      else if (paddr == A_COUNT_HI)
      begin
        n.count[63:32] = pwdata;
      end
      else if (paddr == A_PATTERN)
      begin
        n.pattern = pwdata; // (R20)
      end
      else if (paddr == A_NATIVE_LO)
      begin
        n.native[31:0] = pwdata;
      end
      else if (paddr == A_NATIVE_HI)
      begin
        n.native[63:32] = pwdata;
      end
      else if (paddr == A_HIDDEN_LO)
      begin
        n.hidden[31:0] = pwdata;
      end
      else if (paddr == A_HIDDEN_HI)
      begin
        n.hidden[63:32] = pwdata;
      end
      else if (paddr == A_HIDDEN_EN)
      begin
        n.hid_en = pwdata[0]; // (R4)
      end
      else if (paddr == A_DATA)
      begin
        // data outside the receive window is dropped
        if (q.st == ST_RECV) // (R7)
        begin
          sb.wr_en = 1'b1;
          n.wptr   = q.wptr + 7'h01;
          if (q.wptr == SB_LAST)
          begin
            n.st = ST_FETCH;
            if (q.bg)
            begin
              n.cmplt = 1'b1; // (R11)
            end
            else
            begin
              n.tf_stat = TF_ST_BUSY; // (R15)
            end
          end
        end
      end
      else if (paddr == A_EVENT)
      begin
        if (pwdata[EV_USER_WR])
        begin
          clr_init = 1'b1; // (R9)
        end
        // read reallocation: flag untouched
        if (pwdata[EV_RD_REALOC])
        begin
          n.realloc = n.realloc + 32'h0000_0001; // (R10)
        end
        if (pwdata[EV_NEW_CMD] && !pwdata[EV_IS_STATUS] && q.active && q.bg) // (R12)
        begin
          n.st        = ST_IDLE;
          n.active    = 1'b0;
          n.med_valid = 1'b0;
          n.med_last  = 1'b0;
          n.sct_err   = EXT_BG_ABORT; // (R14)
          set_init    = 1'b0;
        end
      end
    end

    // a completion in the same cycle as a clear keeps the flag set
    n.init = (q.init & ~clr_init) | set_init; // (R8) (R9)
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q         <= '0;
      q.st      <= ST_IDLE;
      q.native  <= NATIVE_RST;
      q.tf_stat <= TF_ST_OK;
    end
    else
    begin
      q <= n;
    end
  end

  assign prdata      = q.prdata;
  assign pready      = q.pready;
  assign pslverr     = q.pslverr;
  assign med_valid   = q.med_valid;
  assign med_data    = q.med_data;
  assign med_lba     = q.med_lba;
  assign med_last    = q.med_last;
  assign fill_active = q.active;
  assign cmd_cmplt   = q.cmplt;

endmodule

// ==== rwf_pkg.sv ====
// Behaviour
// (R1) accepted command: error 00h, status 50h, cylinder low 01h, cylinder high 00h
// (R2) write from start address upward, one per sector, until count sectors done
// (R3) count of zero fills from start through the last user block
// (R4) last user block comes from hidden-area setting; hidden blocks never written
// (R5) automatic sector reassignment is allowed during the fill
// (R6) start or start plus count beyond last user block: error, nothing executed
// (R7) host sends sector data only after task file shows drive ready for it
// (R8) error-free fill of every user sector sets the initialized flag
// (R9) any other user sector write clears the initialized flag
// (R10) reallocations caused by reads leave the initialized flag alone
// (R11) background mode completes once data is received, then keeps filling
// (R12) any new command except status request ends a background fill
// (R13) status error code FFFFh while running, 0000h when done, between on early end
// (R14) background ext status 0008h on host abort, 0009h on unrecoverable error
// (R15) blocking mode completes only after the whole fill has finished
// (R16) on error: status 51h, ext code low in sector count, high in sector number
// (R17) blocking ext status 0017h on unrecoverable error
// (R18) status request shows active or complete, current block address and errors
// (R19) function code picks mode: 0001h, 0002h, 0101h, 0102h
// (R20) pattern mode repeats the 32-bit pattern from key words 10 and 11
// (R21) in blocking mode host waits for completion before its next command
package rwf_pkg;

  // function codes
  localparam logic [15:0] FN_BG_PAT  = 16'h0001;
  localparam logic [15:0] FN_BG_SEC  = 16'h0002;
  localparam logic [15:0] FN_BLK_PAT = 16'h0101;
  localparam logic [15:0] FN_BLK_SEC = 16'h0102;

  // task file values
  localparam logic [7:0] TF_ST_OK    = 8'h50;
  localparam logic [7:0] TF_ST_ERR   = 8'h51;
  localparam logic [7:0] TF_ST_BUSY  = 8'h80;
  localparam logic [7:0] TF_ER_ABORT = 8'h04;
  localparam logic [7:0] TF_XFER_LO  = 8'h01;
  localparam logic [7:0] TF_XFER_HI  = 8'h00;

  // extended status codes
  localparam logic [15:0] EXT_OK        = 16'h0000;
  localparam logic [15:0] EXT_RUN       = 16'hFFFF;
  localparam logic [15:0] EXT_BG_ABORT  = 16'h0008;
  localparam logic [15:0] EXT_BG_UNREC  = 16'h0009;
  localparam logic [15:0] EXT_BLK_UNREC = 16'h0017;
  localparam logic [15:0] EXT_BAD_FUNC  = 16'h0001;
  localparam logic [15:0] EXT_RANGE     = 16'h0005;

  // register byte offsets
  localparam logic [7:0] A_FUNC     = 8'h00;
  localparam logic [7:0] A_START_LO = 8'h04;
  localparam logic [7:0] A_START_HI = 8'h08;
  localparam logic [7:0] A_COUNT_LO = 8'h0C;
  localparam logic [7:0] A_COUNT_HI = 8'h10;
  localparam logic [7:0] A_PATTERN  = 8'h14;
  localparam logic [7:0] A_NATIVE_LO = 8'h18;
  localparam logic [7:0] A_NATIVE_HI = 8'h1C;
  localparam logic [7:0] A_HIDDEN_LO = 8'h20;
  localparam logic [7:0] A_HIDDEN_HI = 8'h24;
  localparam logic [7:0] A_HIDDEN_EN = 8'h28;
  localparam logic [7:0] A_EVENT    = 8'h2C;
  localparam logic [7:0] A_DATA     = 8'h30;
  localparam logic [7:0] A_TF_A     = 8'h34;
  localparam logic [7:0] A_TF_B     = 8'h38;
  localparam logic [7:0] A_SCT_STAT = 8'h3C;
  localparam logic [7:0] A_LBA_LO   = 8'h40;
  localparam logic [7:0] A_LBA_HI   = 8'h44;
  localparam logic [7:0] A_REALLOC  = 8'h48;

  // event register bits
  localparam int EV_NEW_CMD   = 0;
  localparam int EV_IS_STATUS = 1;
  localparam int EV_USER_WR   = 2;
  localparam int EV_RD_REALOC = 3;

  // status flag bits
  localparam int FL_INIT   = 0;
  localparam int FL_ACTIVE = 1;

  // sector buffer: 512 bytes as 128 words
  localparam int         SB_WORDS = 128;
  localparam logic [6:0] SB_LAST  = 7'h7F;

  localparam logic [63:0] NATIVE_RST = 64'h0000_0000_0000_FFFF;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_FETCH,
    ST_LOAD,
    ST_SEND
  } rwf_state_t;

  typedef struct packed {
    rwf_state_t  st;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [15:0] func;
    logic [63:0] start;
    logic [63:0] count;
    logic [31:0] pattern;
    logic [63:0] native;
    logic [63:0] hidden;
    logic        hid_en;
    logic [63:0] lba;
    logic [63:0] end_lba;
    logic        whole;
    logic        bg;
    logic        sec;
    logic        active;
    logic [7:0]  tf_err;
    logic [7:0]  tf_cnt;
    logic [7:0]  tf_num;
    logic [7:0]  tf_cyl_lo;
    logic [7:0]  tf_cyl_hi;
    logic [7:0]  tf_stat;
    logic [15:0] sct_err;
    logic        init;
    logic [31:0] realloc;
    logic [6:0]  wptr;
    logic [6:0]  widx;
    logic        med_valid;
    logic [31:0] med_data;
    logic [63:0] med_lba;
    logic        med_last;
    logic        cmplt;
  } rwf_regs_t;

endpackage

// ==== rwf_sbuf_if.sv ====
`timescale 1ns/1ns
interface rwf_sbuf_if;
  logic        wr_en;
  logic [6:0]  wr_addr;
  logic [31:0] wr_data;
  logic [6:0]  rd_addr;
  logic [31:0] rd_data;

  modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
  modport user (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
endinterface

// ==== rwf_sbuf.sv ====
`timescale 1ns/1ns
module rwf_sbuf
  import rwf_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // buffer port
  rwf_sbuf_if.mem   bus
);

  typedef struct packed {
    logic [SB_WORDS-1:0][31:0] mem;
    logic [31:0]               rd;
  } rwf_sbuf_t;

  rwf_sbuf_t q;
  rwf_sbuf_t n;

  always_comb
  begin
    n = q;
    if (bus.wr_en)
    begin
      n.mem[bus.wr_addr] = bus.wr_data;
    end
    // registered read: data one cycle after the address
    n.rd = q.mem[bus.rd_addr];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  assign bus.rd_data = q.rd;

endmodule

// ==== rwf_fill_props.sv ====
`timescale 1ns/1ns
module rwf_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // media
  input wire logic        med_valid,
  input wire logic [31:0] med_data,
  input wire logic [63:0] med_lba,
  input wire logic        med_last,
  input wire logic        med_ready,
  // status
  input wire logic        fill_active,
  input wire logic        cmd_cmplt
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // last accepted word, forgotten between fills so a new start is free
  logic        seen_r;
  logic        last_r;
  logic [63:0] lba_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      seen_r <= 1'h0;
      last_r <= 1'h0;
      lba_r  <= 64'h0;
    end
    else if (!fill_active)
      seen_r <= 1'h0;
    else if (med_valid && med_ready)
    begin
      seen_r <= 1'h1;
      last_r <= med_last;
      lba_r  <= med_lba;
    end

  a_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  a_word_held: assert property (med_valid && !med_ready && fill_active |=>
    !fill_active || (med_valid && $stable(med_data) && $stable(med_lba)))
    else $error("media word changed before acceptance");
  a_word_gap: assert property (med_valid && med_ready |=> !med_valid)
    else $error("media word repeated");
  a_next_word: assert property (med_valid && med_ready && !med_last |->
    ##[1:4] (med_valid || !fill_active))
    else $error("sector stream stalled");
  a_lba_step: assert property ($rose(med_valid) && seen_r |->
    med_lba == (last_r ? lba_r + 64'h1 : lba_r))
    else $error("media address out of order");
  a_no_idle_write: assert property (med_valid |-> fill_active)
    else $error("media write without active fill");
  a_cmplt_pulse: assert property (cmd_cmplt |=> !cmd_cmplt)
    else $error("completion longer than one cycle");

  c_sector_done: cover property (med_valid && med_ready && med_last);
  c_bg_cmplt: cover property (cmd_cmplt && fill_active);
  c_bad_addr: cover property (pslverr);
endmodule

bind rwf_fill rwf_chk u_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready,
  .pslverr, .med_valid, .med_data, .med_lba, .med_last, .med_ready, .fill_active,
  .cmd_cmplt);

// ==== rwf_media_sink.sv ====
`timescale 1ns/1ns
module rwf_media_sink (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // media stream
  input  wire logic        med_valid,
  input  wire logic [31:0] med_data,
  input  wire logic [63:0] med_lba,
  input  wire logic        med_last,
  output      logic        med_ready,
  output      logic        med_error,
  output      logic        med_realloc,
  // scenario control
  input  wire logic        slow,
  input  wire logic        err_en,
  input  wire logic        rel_en,
  input  wire logic        clr,
  // record
  output      logic [15:0] n_words,
  output      logic [63:0] first_lba,
  output      logic [63:0] last_lba,
  output      logic [31:0] last_data
);
  logic [1:0] ph;
  logic       acc;
  assign acc = med_valid && med_ready;
  // slow mode takes one word in four cycles
  assign med_ready = !slow || ph == 2'h3;
  assign med_error = err_en && med_last;
  assign med_realloc = rel_en && acc && med_last;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ph      <= 2'h0;
      n_words <= 16'h0;
    end
    else
    begin
      ph <= ph + 2'h1;
      if (clr)
        n_words <= 16'h0;
      else if (acc)
      begin
        if (n_words == 16'h0)
          first_lba <= med_lba;
        n_words   <= n_words + 16'h1;
        last_lba  <= med_lba;
        last_data <= med_data;
      end
    end
endmodule

// ==== rwf_fill_tb.sv ====
`timescale 1ns/1ns
module rwf_fill_tb
  import rwf_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, med_data, last_data, rd;
  logic        med_valid, med_last, med_ready, med_error, med_realloc;
  logic        fill_active, cmd_cmplt, slow, err_en, rel_en, clr, slv;
  logic [63:0] med_lba, first_lba, last_lba;
  logic [15:0] n_words;
  int          mismatches, n_tests, n_cmplt, c0;

  rwf_fill u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .med_valid, .med_data, .med_lba, .med_last,
    .med_ready, .med_error, .med_realloc, .fill_active, .cmd_cmplt);
  rwf_media_sink u_sink (.pclk, .presetn, .med_valid, .med_data, .med_lba,
    .med_last, .med_ready, .med_error, .med_realloc, .slow, .err_en, .rel_en,
    .clr, .n_words, .first_lba, .last_lba, .last_data);

  initial
  begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end

  // counted mid-cycle so a task waking on the next rising edge sees the count
  always @(negedge pclk)
    if (cmd_cmplt === 1'h1)
      n_cmplt++;

  task automatic finish_test;
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // only the watchdog ends a wait for the answer
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    slv = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic key(input logic [63:0] s, input logic [63:0] c, input logic [15:0] f);
    c0 = n_cmplt;
    @(posedge pclk);
    clr <= 1'h1;
    @(posedge pclk);
    clr <= 1'h0;
    apb(1'h1, A_START_LO, s[31:0]);
    apb(1'h1, A_START_HI, s[63:32]);
    apb(1'h1, A_COUNT_LO, c[31:0]);
    apb(1'h1, A_COUNT_HI, c[63:32]);
    apb(1'h1, A_FUNC, {16'h0, f});
    repeat (3) @(posedge pclk);
  endtask

  // bounded so a stuck fill cannot hang the run
  task automatic idle;
    int n;
    n = 0;
    while (fill_active !== 1'h0 && n < 20000)
    begin
      @(posedge pclk);
      n++;
    end
    chk(fill_active, 1'h0);
  endtask

  task automatic send_sector;
    for (int i = 0; i < SB_WORDS; i++)
      apb(1'h1, A_DATA, 32'hC0DE_0000 + i);
  endtask

  task automatic t_reset;
    apb(1'h0, A_TF_B, 32'h0);
    chk(rd[15:0], 16'h5000);
    apb(1'h0, A_SCT_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 8'h4C, 32'h0);
    chk(slv, 1'h1);
  endtask

  task automatic t_bg_pattern;
    apb(1'h1, A_PATTERN, 32'hA5C3_1E0F);
    key(64'h5, 64'h2, FN_BG_PAT);
    chk(n_cmplt, c0 + 1);
    apb(1'h0, A_TF_A, 32'h0);
    chk(rd, 32'h0001_0000);
    apb(1'h0, A_TF_B, 32'h0);
    chk(rd[15:0], 16'h5000);
    apb(1'h0, A_SCT_STAT, 32'h0);
    chk({rd[17], rd[15:0]}, 17'h1_FFFF);
    idle();
    chk({n_words, first_lba, last_lba}, {16'h100, 64'h5, 64'h6});
    chk(last_data, 32'hA5C3_1E0F);
    apb(1'h0, A_LBA_LO, 32'h0);
    chk(rd, 32'h6);
    apb(1'h0, A_SCT_STAT, 32'h0);
    chk(rd[15:0], 16'h0);
  endtask

  task automatic t_range;
    key(64'h1_0000_0000, 64'h0, FN_BG_PAT);
    chk({fill_active, n_words}, 17'h0);
    apb(1'h0, A_TF_B, 32'h0);
    chk(rd[15:0], 16'h5104);
    apb(1'h0, A_TF_A, 32'h0);
    chk(rd[15:0], 16'h0005);
    key(64'h0, 64'h1, 16'h0003);
    apb(1'h0, A_TF_A, 32'h0);
    chk({fill_active, rd}, 33'h0_0000_0001);
  endtask

  task automatic t_blk_err;
    err_en <= 1'h1;
    key(64'h7, 64'h1, FN_BLK_SEC);
    send_sector();
    chk(n_cmplt, c0);
    idle();
    chk(n_cmplt, c0 + 1);
    chk({last_lba, last_data}, {64'h7, 32'hC0DE_007F});
    apb(1'h0, A_TF_B, 32'h0);
    chk(rd[15:0], 16'h5104);
    apb(1'h0, A_TF_A, 32'h0);
    chk(rd[15:0], 16'h0017);
    err_en <= 1'h0;
  endtask

  task automatic t_bg_abort;
    slow <= 1'h1;
    key(64'h0, 64'h4, FN_BG_SEC);
    send_sector();
    repeat (3) @(posedge pclk);
    chk({fill_active, 32'(n_cmplt)}, {1'h1, 32'(c0 + 1)});
    apb(1'h1, A_EVENT, 32'h3);
    chk(fill_active, 1'h1);
    apb(1'h1, A_EVENT, 32'h1);
    repeat (2) @(posedge pclk);
    chk(fill_active, 1'h0);
    apb(1'h0, A_SCT_STAT, 32'h0);
    chk(rd[15:0], 16'h0008);
    slow <= 1'h0;
  endtask

  task automatic t_whole;
    logic [31:0] r0;
    rel_en <= 1'h1;
    apb(1'h0, A_REALLOC, 32'h0);
    r0 = rd;
    apb(1'h1, A_HIDDEN_LO, 32'h3);
    apb(1'h1, A_HIDDEN_HI, 32'h0);
    apb(1'h1, A_HIDDEN_EN, 32'h1);
    key(64'h0, 64'h0, FN_BLK_PAT);
    chk(n_cmplt, c0);
    idle();
    chk({n_words, last_lba}, {16'h200, 64'h3});
    apb(1'h0, A_SCT_STAT, 32'h0);
    chk(rd[16], 1'h1);
    apb(1'h0, A_REALLOC, 32'h0);
    chk(rd, r0 + 32'h4);
    apb(1'h1, A_EVENT, 32'h8);
    apb(1'h0, A_SCT_STAT, 32'h0);
    chk(rd[16], 1'h1);
    apb(1'h1, A_EVENT, 32'h4);
    apb(1'h0, A_SCT_STAT, 32'h0);
    chk(rd[16], 1'h0);
    rel_en <= 1'h0;
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {slow, err_en, rel_en, clr} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_bg_pattern();
    t_range();
    t_blk_err();
    t_bg_abort();
    t_whole();
    finish_test();
  end

  initial
  begin
    #300000;
    mismatches++;
    finish_test();
  end
endmodule
